//--- verilog/psfs_pkg.sv
package psfs_pkg;

   // System clock rate, 50 ns period.
   localparam int CLK_MHZ = 20;
   // Loss-of-superframe timeout, fixed inside the allowed 1 to 5 ms window.
   localparam int LOM_TIME_US = 3000;
   localparam int LOM_CYCLES = LOM_TIME_US * CLK_MHZ;

   localparam int NUM_SINKS = 14;
   localparam int SLOT_W = 4;
   localparam int LABEL_ACCEPT_FRAMES = 5;
   localparam int IM_GOOD_FRAMES = 4;

   // Bit positions in the overhead label byte, MSB is bit 7 of the byte.
   localparam int LABEL_MSB = 5;
   localparam int LABEL_LSB = 3;
   localparam int SF_MSB = 2;
   localparam int SF_LSB = 1;
   localparam logic [2:0] LABEL_EXPECTED = 3'h3;
   localparam logic [1:0] SF_FIRST_PHASE = 2'h0;

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SLOTMAP0 = 8'h04;
   localparam logic [7:0] ADDR_SLOTMAP1 = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
   localparam logic [7:0] ADDR_INT_MASK = 8'h14;

   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_SINK_LSB = 16;
   localparam int MAPS_PER_REG = 8;

   localparam int ST_IM_BIT = 0;
   localparam int ST_PLM_BIT = 1;
   localparam int ST_LOM_BIT = 2;
   localparam int ST_PLM_FAULT_BIT = 3;
   localparam int ST_LOM_FAULT_BIT = 4;
   localparam int ST_SSF_BIT = 5;
   localparam int ST_LABEL_LSB = 8;
   localparam int ST_PHASE_LSB = 12;

   localparam int INT_W = 3;
   localparam int INT_PLM_BIT = 0;
   localparam int INT_LOM_BIT = 1;
   localparam int INT_OOM_BIT = 2;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [2:0] INT_MASK_RESET = 3'h0;

   typedef enum logic [1:0] {
      SF_OOM = 2'b01,
      SF_IM = 2'b10
   } psfs_sf_state_type;

   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic frame_start;
      logic label_byte;
   } psfs_path_in_type;

   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic frame_start;
      logic superframe_start_out;
   } psfs_sink_out_type;

endpackage

//--- verilog/psfs_label_sf_sink.sv
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Compare accepted label against expected 011.
// - Align superframe on two bits, mark start.
// - One sequence error enters out-of-superframe.
// - Four good consecutive frames regain alignment.
// - Disabled: force fail, hide fault reports.
// - Lost superframe after fixed timeout out.
// - Lost superframe clears on realignment.
// - Mismatch defect from accepted label differing.
// - Lost superframe fault needs no trail fail, mismatch.
// - Fourteen sinks, each picks slot 0 to 13.
// - Several sinks may share one slot.
// - All sinks may be enabled together.
module psfs_label_sf_sink #(
   parameter int LOM_CYCLES = psfs_pkg::LOM_CYCLES
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire psfs_pkg::psfs_path_in_type path_in,
   input wire logic upstream_trail_fail,
   input wire logic [7:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata,
   output var psfs_pkg::psfs_sink_out_type sink_out,
   output logic [psfs_pkg::NUM_SINKS-1:0] sink_strobe,
   output logic server_signal_fail,
   output logic label_mismatch_fault,
   output logic lost_superframe_fault,
   output logic irq
);

   localparam int NS = psfs_pkg::NUM_SINKS;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   logic function_enable, next_function_enable;
   logic [NS-1:0] sink_en, next_sink_en;
   logic [psfs_pkg::SLOT_W-1:0] slot_map [NS];
   logic [psfs_pkg::SLOT_W-1:0] next_slot_map [NS];
   logic [psfs_pkg::INT_W-1:0] int_status, next_int_status, int_mask, next_int_mask;
   logic [psfs_pkg::INT_W-1:0] int_event;
   logic [31:0] next_bus_rdata;
   logic next_irq;

   psfs_pkg::psfs_sf_state_type sf_state, next_sf_state;
   logic [1:0] sf_prev, next_sf_prev;
   logic [2:0] good_cnt, next_good_cnt;
   logic [2:0] cand_label, next_cand_label, accepted, next_accepted;
   logic [2:0] accept_cnt, next_accept_cnt;
   logic plm, next_plm, lom, next_lom;
   logic [31:0] lom_timer, next_lom_timer;
   logic [psfs_pkg::SLOT_W-1:0] slot_cnt, next_slot_cnt, cur_slot;

   logic lbl_beat, sf_ok, in_im;
   logic [2:0] rx_label;
   logic [1:0] rx_sf;

   psfs_pkg::psfs_sink_out_type next_sink_out;
   logic [NS-1:0] next_sink_strobe;
   logic next_ssf, next_plm_fault, next_lom_fault;

   assign lbl_beat = path_in.valid & path_in.label_byte;
   assign rx_label = path_in.data[psfs_pkg::LABEL_MSB:psfs_pkg::LABEL_LSB];
   assign rx_sf = path_in.data[psfs_pkg::SF_MSB:psfs_pkg::SF_LSB];
   assign sf_ok = (rx_sf == 2'(sf_prev + 2'h1));
   assign in_im = (sf_state == psfs_pkg::SF_IM);

   // Register file and interrupt logic.
   always_comb begin
      next_function_enable = function_enable;
      next_sink_en = sink_en;
      next_slot_map = slot_map;
      next_int_mask = int_mask;
      next_int_status = int_status;
      next_bus_rdata = 32'h0000_0000;
      if (bus_wr) begin
         case (bus_addr)
            psfs_pkg::ADDR_CTRL: begin
               next_function_enable = bus_wdata[psfs_pkg::CTRL_EN_BIT];
               next_sink_en = bus_wdata[psfs_pkg::CTRL_SINK_LSB +: NS];
            end
            psfs_pkg::ADDR_INT_STATUS: next_int_status = int_status & ~bus_wdata[psfs_pkg::INT_W-1:0];
            psfs_pkg::ADDR_INT_MASK: next_int_mask = bus_wdata[psfs_pkg::INT_W-1:0];
            default: ;
         endcase
      end
      for (int i = 0; i < NS; i++) begin
         if (bus_wr && bus_addr == ((i < psfs_pkg::MAPS_PER_REG) ?
               psfs_pkg::ADDR_SLOTMAP0 : psfs_pkg::ADDR_SLOTMAP1)) begin
            next_slot_map[i] = bus_wdata[(i % psfs_pkg::MAPS_PER_REG) * psfs_pkg::SLOT_W +: psfs_pkg::SLOT_W];
         end
      end
      // An event in the clearing cycle still sets its bit.
      next_int_status = next_int_status | int_event;
      if (bus_rd) begin
         case (bus_addr)
            psfs_pkg::ADDR_CTRL: begin
               next_bus_rdata[psfs_pkg::CTRL_EN_BIT] = function_enable;
               next_bus_rdata[psfs_pkg::CTRL_SINK_LSB +: NS] = sink_en;
            end
            psfs_pkg::ADDR_SLOTMAP0, psfs_pkg::ADDR_SLOTMAP1: begin
               for (int i = 0; i < NS; i++) begin
                  if (bus_addr == ((i < psfs_pkg::MAPS_PER_REG) ?
                        psfs_pkg::ADDR_SLOTMAP0 : psfs_pkg::ADDR_SLOTMAP1)) begin
                     next_bus_rdata[(i % psfs_pkg::MAPS_PER_REG) * psfs_pkg::SLOT_W +: psfs_pkg::SLOT_W] = slot_map[i];
                  end
               end
            end
            psfs_pkg::ADDR_STATUS: begin
               next_bus_rdata[psfs_pkg::ST_IM_BIT] = in_im;
               next_bus_rdata[psfs_pkg::ST_PLM_BIT] = plm;
               next_bus_rdata[psfs_pkg::ST_LOM_BIT] = lom;
               next_bus_rdata[psfs_pkg::ST_PLM_FAULT_BIT] = label_mismatch_fault;
               next_bus_rdata[psfs_pkg::ST_LOM_FAULT_BIT] = lost_superframe_fault;
               next_bus_rdata[psfs_pkg::ST_SSF_BIT] = server_signal_fail;
               next_bus_rdata[psfs_pkg::ST_LABEL_LSB +: 3] = accepted;
               next_bus_rdata[psfs_pkg::ST_PHASE_LSB +: 2] = sf_prev;
            end
            psfs_pkg::ADDR_INT_STATUS: next_bus_rdata[psfs_pkg::INT_W-1:0] = int_status;
            psfs_pkg::ADDR_INT_MASK: next_bus_rdata[psfs_pkg::INT_W-1:0] = int_mask;
            default: ;
         endcase
      end
      next_irq = |(next_int_status & next_int_mask);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         function_enable <= psfs_pkg::CTRL_RESET[psfs_pkg::CTRL_EN_BIT];
         sink_en <= psfs_pkg::CTRL_RESET[psfs_pkg::CTRL_SINK_LSB +: NS];
         for (int i = 0; i < NS; i++) begin
            slot_map[i] <= psfs_pkg::SLOT_W'(i);
         end
         int_status <= '0;
         int_mask <= psfs_pkg::INT_MASK_RESET;
         bus_rdata <= 32'h0000_0000;
         irq <= 1'b0;
      end else begin
         function_enable <= next_function_enable;
         sink_en <= next_sink_en;
         slot_map <= next_slot_map;
         int_status <= next_int_status;
         int_mask <= next_int_mask;
         bus_rdata <= next_bus_rdata;
         irq <= next_irq;
      end
   end

   // Label acceptance, superframe alignment and loss timer.
   always_comb begin
      next_sf_state = sf_state;
      next_sf_prev = sf_prev;
      next_good_cnt = good_cnt;
      next_cand_label = cand_label;
      next_accept_cnt = accept_cnt;
      next_accepted = accepted;
      next_lom = lom;
      next_lom_timer = lom_timer;
      if (lbl_beat) begin
         if (rx_label == cand_label) begin
            if (accept_cnt == 3'(psfs_pkg::LABEL_ACCEPT_FRAMES - 2)) begin
               next_accepted = rx_label;
            end
            if (accept_cnt != 3'(psfs_pkg::LABEL_ACCEPT_FRAMES - 1)) begin
               next_accept_cnt = 3'(accept_cnt + 3'h1);
            end
         end else begin
            next_cand_label = rx_label;
            next_accept_cnt = 3'h0;
         end
         next_sf_prev = rx_sf;
         unique case (sf_state)
            psfs_pkg::SF_IM: begin
               if (!sf_ok) begin
                  next_sf_state = psfs_pkg::SF_OOM;
                  next_good_cnt = 3'h0;
               end
            end
            psfs_pkg::SF_OOM: begin
               if (!sf_ok) begin
                  next_good_cnt = 3'h0;
               end else if (good_cnt == 3'(psfs_pkg::IM_GOOD_FRAMES - 1)) begin
                  next_sf_state = psfs_pkg::SF_IM;
                  next_good_cnt = 3'h0;
               end else begin
                  next_good_cnt = 3'(good_cnt + 3'h1);
               end
            end
         endcase
      end
      next_plm = (next_accepted != psfs_pkg::LABEL_EXPECTED);
      if (next_sf_state == psfs_pkg::SF_IM) begin
         next_lom = 1'b0;
         next_lom_timer = 32'h0000_0000;
      end else if (!lom) begin
         if (lom_timer == 32'(LOM_CYCLES - 1)) begin
            next_lom = 1'b1;
         end
         next_lom_timer = lom_timer + 32'h0000_0001;
      end
      int_event = '0;
      int_event[psfs_pkg::INT_PLM_BIT] = next_plm & ~plm;
      int_event[psfs_pkg::INT_LOM_BIT] = next_lom & ~lom;
      int_event[psfs_pkg::INT_OOM_BIT] = in_im & (next_sf_state == psfs_pkg::SF_OOM);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         sf_state <= psfs_pkg::SF_OOM;
         sf_prev <= 2'h0;
         good_cnt <= 3'h0;
         cand_label <= 3'h0;
         accept_cnt <= 3'h0;
         accepted <= 3'h0;
         plm <= 1'b0;
         lom <= 1'b0;
         lom_timer <= 32'h0000_0000;
      end else begin
         sf_state <= next_sf_state;
         sf_prev <= next_sf_prev;
         good_cnt <= next_good_cnt;
         cand_label <= next_cand_label;
         accept_cnt <= next_accept_cnt;
         accepted <= next_accepted;
         plm <= next_plm;
         lom <= next_lom;
         lom_timer <= next_lom_timer;
      end
   end

   // Slot tracking and the sink-facing stream.
   assign cur_slot = path_in.frame_start ? '0 : slot_cnt;

   always_comb begin
      next_slot_cnt = slot_cnt;
      if (path_in.valid && !path_in.label_byte) begin
         next_slot_cnt = (cur_slot == psfs_pkg::SLOT_W'(NS - 1)) ? '0 :
            psfs_pkg::SLOT_W'(cur_slot + 1'b1);
      end
      next_sink_out.data = path_in.data;
      next_sink_out.valid = path_in.valid & ~path_in.label_byte;
      next_sink_out.frame_start = path_in.valid & path_in.frame_start;
      // The phase after the last received one tells where this frame sits.
      next_sink_out.superframe_start_out = path_in.valid & path_in.frame_start & in_im &
         (2'(sf_prev + 2'h1) == psfs_pkg::SF_FIRST_PHASE);
      next_ssf = ~function_enable | plm | lom;
      next_plm_fault = function_enable & plm & ~upstream_trail_fail;
      next_lom_fault = function_enable & lom & ~upstream_trail_fail & ~plm;
   end

   // Each sink reads whatever slot its map selects, so shared slots work.
   for (genvar g = 0; g < NS; g++) begin : g_sink
      assign next_sink_strobe[g] = path_in.valid & ~path_in.label_byte & sink_en[g] &
         (slot_map[g] == cur_slot);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         slot_cnt <= '0;
         sink_out <= '0;
         sink_strobe <= '0;
         server_signal_fail <= 1'b1;
         label_mismatch_fault <= 1'b0;
         lost_superframe_fault <= 1'b0;
      end else begin
         slot_cnt <= next_slot_cnt;
         sink_out <= next_sink_out;
         sink_strobe <= next_sink_strobe;
         server_signal_fail <= next_ssf;
         label_mismatch_fault <= next_plm_fault;
         lost_superframe_fault <= next_lom_fault;
      end
   end

   a_oom_on_error: assert property (lbl_beat && !sf_ok |=> sf_state == psfs_pkg::SF_OOM)
      else $error("sequence error did not leave alignment");
   a_im_after_four: assert property ($rose(in_im) |-> $past(good_cnt) == 3'(psfs_pkg::IM_GOOD_FRAMES - 1)
      && $past(lbl_beat && sf_ok))
      else $error("alignment regained without four good frames");
   a_lom_timeout: assert property ($rose(lom) |-> $past(lom_timer) == 32'(LOM_CYCLES - 1)
      && !$past(in_im))
      else $error("loss defect raised at wrong time");
   a_lom_clear_im: assert property (in_im |-> !lom)
      else $error("loss defect held while aligned");
   a_label_accept: assert property ($changed(accepted) |-> $past(lbl_beat)
      && $past(accept_cnt) == 3'(psfs_pkg::LABEL_ACCEPT_FRAMES - 2))
      else $error("label accepted too early");
   a_plm_fault_gate: assert property (label_mismatch_fault |-> $past(plm && !upstream_trail_fail
      && function_enable))
      else $error("mismatch fault without cause");
   a_lom_fault_gate: assert property (lost_superframe_fault |-> $past(lom && !upstream_trail_fail
      && !plm && function_enable))
      else $error("loss fault reported wrongly");
   a_disable_fail: assert property (!function_enable |=> server_signal_fail && !label_mismatch_fault
      && !lost_superframe_fault)
      else $error("disabled block not failing");
   a_defect_fail: assert property (plm || lom |=> server_signal_fail)
      else $error("defect without server fail");
   a_sink_strobe: assert property (sink_strobe[0] |-> $past(sink_en[0] && path_in.valid
      && !path_in.label_byte && slot_map[0] == cur_slot))
      else $error("sink strobe without selected slot");
   a_sf_start: assert property (sink_out.superframe_start_out |-> $past(in_im))
      else $error("superframe start while unaligned");

   c_regain: cover property ($rose(in_im));
   c_lom: cover property ($rose(lom));
   c_plm: cover property ($rose(label_mismatch_fault));
   c_shared_slot: cover property (sink_strobe[0] && sink_strobe[1]);

endmodule

`default_nettype wire

//--- verification/psfs_path_src_model.sv
`timescale 1ns/1ps
`default_nettype none

// Upstream path source: back-to-back frames of 15 beats, always valid.
// Beat 0 opens the frame and carries payload, beat 1 is the overhead label byte, beats 2 to 14 are payload.
// The label byte carries the structure label in bits 5:3 and the superframe phase in bits 2:1.
// While phase_hold is high the phase stops advancing, so every label after the first breaks the sequence.
module psfs_path_src_model (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [2:0] label_code,
   input wire logic phase_hold,
   output var psfs_pkg::psfs_path_in_type path_out
);
   logic [3:0] beat;
   logic [1:0] phase;
   logic [7:0] fill;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         beat <= 4'h0;
         phase <= 2'h0;
         fill <= 8'h00;
         path_out <= '0;
      end else begin
         path_out.valid <= 1'b1;
         path_out.frame_start <= (beat == 4'h0);
         path_out.label_byte <= (beat == 4'h1);
         path_out.data <= (beat == 4'h1) ? {2'b10, label_code, phase, 1'b0} : fill;
         if (beat == 4'h1 && !phase_hold) begin
            phase <= phase + 2'h1;
         end
         beat <= (beat == 4'he) ? 4'h0 : beat + 4'h1;
         fill <= fill + 8'h01;
      end
   end
endmodule

`default_nettype wire

//--- verification/tb_path_label_superframe_sink.sv
`timescale 1ns/1ps
`default_nettype none

module tb_path_label_superframe_sink;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic upstream_trail_fail = 1'b0;
   logic [7:0] bus_addr = 8'h00;
   logic [31:0] bus_wdata = 32'h0000_0000;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [2:0] label_code = 3'h3;
   logic phase_hold = 1'b0;
   psfs_pkg::psfs_path_in_type path_in;
   psfs_pkg::psfs_sink_out_type sink_out;
   logic [31:0] bus_rdata;
   logic [13:0] sink_strobe;
   logic server_signal_fail;
   logic label_mismatch_fault;
   logic lost_superframe_fault;
   logic irq;
   logic [31:0] rd_val;
   int err_total = 0;
   int checks = 0;
   int sf_cnt = 0;
   int sf_bad = 0;
   int sf_snap;
   int fwd_bad = 0;
   logic fwd_armed = 1'b0;
   logic [9:0] fwd_exp;

   always #25 clk_sys = ~clk_sys;

   psfs_path_src_model src_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .label_code(label_code),
      .phase_hold(phase_hold), .path_out(path_in));

   psfs_label_sf_sink #(.LOM_CYCLES(50)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .path_in(path_in), .upstream_trail_fail(upstream_trail_fail), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .sink_out(sink_out), .sink_strobe(sink_strobe), .server_signal_fail(server_signal_fail),
      .label_mismatch_fault(label_mismatch_fault),
      .lost_superframe_fault(lost_superframe_fault), .irq(irq));

   // Superframe starts must only ever sit on a frame start beat, and every beat
   // comes out one cycle later, with the label byte marked as not valid.
   always @(posedge clk_sys) begin
      if (sink_out.superframe_start_out === 1'b1) begin
         sf_cnt++;
         if (sink_out.frame_start !== 1'b1) begin
            sf_bad++;
         end
      end
      if (fwd_armed && {sink_out.data, sink_out.valid, sink_out.frame_start} !== fwd_exp) begin
         fwd_bad++;
      end
      fwd_exp = {path_in.data, path_in.valid & ~path_in.label_byte,
         path_in.valid & path_in.frame_start};
      fwd_armed = ~sys_rst;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk_sys);
      bus_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk_sys);
      bus_rd <= 1'b0;
      #1;
      d = bus_rdata;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic final_report;
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk_sys);
      err_total++;
      final_report();
   end

   initial begin
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      #1;
      chk(server_signal_fail, 1);
      rd(psfs_pkg::ADDR_CTRL, rd_val);
      chk(rd_val, 32'h0000_0000);
      rd(psfs_pkg::ADDR_SLOTMAP0, rd_val);
      chk(rd_val, 32'h7654_3210);
      rd(psfs_pkg::ADDR_SLOTMAP1, rd_val);
      chk(rd_val, 32'h00dc_ba98);
      rd(psfs_pkg::ADDR_INT_MASK, rd_val);
      chk(rd_val, 32'h0000_0000);
      rd(8'h20, rd_val);
      chk(rd_val, 32'h0000_0000);
      wr(psfs_pkg::ADDR_CTRL, 32'h0000_0001);
      step(150);
      rd(psfs_pkg::ADDR_STATUS, rd_val);
      chk(rd_val & 32'h0000_073f, 32'h0000_0301);
      chk(server_signal_fail, 0);
      rd(psfs_pkg::ADDR_INT_STATUS, rd_val);
      chk(rd_val & 32'h0000_0005, 32'h0000_0001);
      wr(psfs_pkg::ADDR_INT_STATUS, 32'h0000_0007);
      rd(psfs_pkg::ADDR_INT_STATUS, rd_val);
      chk(rd_val, 32'h0000_0000);
      sf_snap = sf_cnt;
      step(240);
      chk(sf_cnt - sf_snap, 4);
      chk(sf_bad, 0);
      // Sink 1 shares slot 0 with sink 0, and every sink is enabled.
      wr(psfs_pkg::ADDR_SLOTMAP0, 32'h7654_3200);
      wr(psfs_pkg::ADDR_CTRL, 32'h3fff_0001);
      step(1);
      for (int i = 0; i < 30 && sink_out.frame_start !== 1'b1; i++) begin
         step(1);
      end
      chk(sink_strobe, 14'h0003);
      step(1);
      chk(sink_strobe, 14'h0000);
      step(1);
      chk(sink_strobe, 14'h0000);
      step(1);
      chk(sink_strobe, 14'h0004);
      wr(psfs_pkg::ADDR_INT_MASK, 32'h0000_0004);
      phase_hold <= 1'b1;
      step(40);
      chk(irq, 1);
      chk(lost_superframe_fault, 0);
      step(80);
      chk(lost_superframe_fault, 1);
      chk(server_signal_fail, 1);
      rd(psfs_pkg::ADDR_INT_STATUS, rd_val);
      chk(rd_val & 32'h0000_0006, 32'h0000_0006);
      @(posedge clk_sys);
      upstream_trail_fail <= 1'b1;
      step(3);
      chk(lost_superframe_fault, 0);
      @(posedge clk_sys);
      upstream_trail_fail <= 1'b0;
      wr(psfs_pkg::ADDR_INT_STATUS, 32'h0000_0004);
      step(2);
      chk(irq, 0);
      phase_hold <= 1'b0;
      step(20);
      rd(psfs_pkg::ADDR_STATUS, rd_val);
      chk(rd_val[0], 0);
      step(90);
      rd(psfs_pkg::ADDR_STATUS, rd_val);
      chk(rd_val & 32'h0000_0005, 32'h0000_0001);
      chk(lost_superframe_fault, 0);
      label_code <= 3'h5;
      step(100);
      chk(label_mismatch_fault, 1);
      chk(server_signal_fail, 1);
      chk(lost_superframe_fault, 0);
      @(posedge clk_sys);
      upstream_trail_fail <= 1'b1;
      step(3);
      chk(label_mismatch_fault, 0);
      chk(server_signal_fail, 1);
      @(posedge clk_sys);
      upstream_trail_fail <= 1'b0;
      wr(psfs_pkg::ADDR_CTRL, 32'h0000_0000);
      step(3);
      chk(label_mismatch_fault, 0);
      chk(server_signal_fail, 1);
      rd(psfs_pkg::ADDR_STATUS, rd_val);
      chk(rd_val & 32'h0000_071a, 32'h0000_0502);
      chk(fwd_bad, 0);
      final_report();
   end
endmodule

`default_nettype wire
